/* src/adc_conversion_sequencer.sv */
// Conversion sequencer: start, busy flag, result capture and done request.
// Assumes synchronous inputs and an Avalon-MM master on the register port.
// Operation
// - Successive approximation yields ten-bit results.
// - Flag reads one while converting, self-clears.
// - Flag falling at conversion end sets the done request bit.
// - Interrupt only while done enable is one.
// - Result stored as flag clears, then idle.
// - Trigger needs pin function and trigger enable.
// - Selected trigger edge sets flag, starts conversion.
// - Low power hold freezes the configuration registers; results survive reset.
// - Channel code 0101 selects analog input one.
// - Setting flag again during a conversion is ignored.
// - Writing zero to flag stops conversion.
// - Period 62 cycles, or 31 when fast.
// - Result holds until the next conversion completes.
`include "adc_seq_defs.svh"
module adc_conversion_sequencer #(
  parameter int RES_W = `RES_BITS
) (
  // Clock and reset.
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_in,
  // Avalon-MM slave.
  input  wire logic [3:0]               avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  input  wire logic [3:0]               avs_byteenable_in,
  output logic [31:0]                   avs_readdata_out,
  output logic                          avs_waitrequest_out,
  // Trigger, low-power hold and analog side.
  input  wire logic                     external_trigger_pin_in,
  input  wire logic                     low_power_hold_in,
  input  wire logic                     cmp_above_in,
  output logic [RES_W-1:0]              dac_trial_out,
  output logic [3:0]                    channel_select_field_out,
  output logic                          analog_input_one_sel_out,
  output logic                          converter_clock_on_out,
  // Interrupt.
  output logic                          irq_out
);
  import adc_seq_pkg::*;

  conv_state_e       state_q;
  conv_state_e       state_d;
  reg_byte_t         converter_mode_register_q;
  reg_byte_t         converter_mode_register_d;
  logic              conversion_flag_q;
  logic              conversion_flag_d;
  logic [RES_W-1:0]  result_q;
  logic [RES_W-1:0]  result_d;
  logic              conversion_done_request_q;
  logic              conversion_done_request_d;
  logic              conversion_done_enable_q;
  logic              conversion_done_enable_d;
  logic              trigger_pin_function_bit_q;
  logic              trigger_pin_function_bit_d;
  logic              trigger_edge_select_q;
  logic              trigger_edge_select_d;
  logic              converter_clock_stop_bit_q;
  logic              converter_clock_stop_bit_d;
  logic [6:0]        cycle_q;
  logic [6:0]        cycle_d;
  logic              trig_prev_q;
  logic              ack_q;
  logic              ack_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              irq_q;
  logic              chan_one_q;
  logic [RES_W-1:0]  trial;
  logic              wr_hit;
  logic              rd_hit;
  logic              lane0;
  logic              trig_edge;
  logic              sw_start;
  logic              sw_stop;
  logic              start_req;
  logic              run_ok;
  logic              sar_clear;
  logic              sar_step;
  logic              finish;
  logic [6:0]        period;

  sar_engine #(
    .BITS(RES_W)
  ) u_sar (
    .core_clk_in  (core_clk_in),
    .reset_in     (reset_in),
    .clear_in     (sar_clear),
    .step_in      (sar_step),
    .cmp_above_in (cmp_above_in),
    .trial_out    (trial)
  );

  always_comb
  begin
    wr_hit  = avs_write_in && !ack_q;
    rd_hit  = avs_read_in && !ack_q;
    lane0   = avs_byteenable_in[0];
    run_ok  = !low_power_hold_in && converter_clock_stop_bit_q;
    period  = converter_mode_register_q[`BIT_SPEED] ?
              `CONV_CYC_FAST : `CONV_CYC_SLOW;
    trig_edge = trigger_pin_function_bit_q &&
                converter_mode_register_q[`BIT_TRG_EN] &&
                (trigger_edge_select_q ?
                 (external_trigger_pin_in && !trig_prev_q) :
                 (!external_trigger_pin_in && trig_prev_q));
    sw_start = wr_hit && lane0 && avs_address_in == `OFS_START &&
               avs_writedata_in[`BIT_DONE_FLAG];
    sw_stop  = wr_hit && lane0 && avs_address_in == `OFS_START &&
               !avs_writedata_in[`BIT_DONE_FLAG];
    start_req = (sw_start || trig_edge) && run_ok;
    finish    = state_q == ST_CONV && run_ok && !sw_stop &&
                cycle_q == period - 7'h01;
  end

  always_comb
  begin
    state_d           = state_q;
    conversion_flag_d = conversion_flag_q;
    result_d          = result_q;
    cycle_d           = cycle_q;
    conversion_done_request_d = conversion_done_request_q;
    sar_clear = 1'b0;
    sar_step  = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (start_req)
        begin
          state_d           = ST_CONV;
          conversion_flag_d = 1'b1;
          cycle_d           = 7'h00;
          sar_clear         = 1'b1;
        end
      end
      ST_CONV:
      begin
        if (sw_stop)
        begin
          state_d           = ST_IDLE;
          conversion_flag_d = 1'b0;
        end
        else if (run_ok)
        begin
          // A new start here is ignored; the count runs on.
          cycle_d  = cycle_q + 7'h01;
          // Steps fall on odd counts so the registered trial code has settled.
          sar_step = cycle_q[0] && cycle_q < 7'(2 * RES_W);
          if (finish)
          begin
            result_d          = trial;
            conversion_flag_d = 1'b0;
            state_d           = ST_IDLE;
            conversion_done_request_d = 1'b1;
          end
        end
      end
      default:
      begin
        state_d           = ST_IDLE;
        conversion_flag_d = 1'b0;
      end
    endcase
    if (wr_hit && lane0 && avs_address_in == `OFS_IRQ_STATUS &&
        avs_writedata_in[0] && !finish)
      conversion_done_request_d = 1'b0;
  end

  always_comb
  begin
    converter_mode_register_d  = converter_mode_register_q;
    conversion_done_enable_d   = conversion_done_enable_q;
    trigger_pin_function_bit_d = trigger_pin_function_bit_q;
    trigger_edge_select_d      = trigger_edge_select_q;
    converter_clock_stop_bit_d = converter_clock_stop_bit_q;
    if (wr_hit && lane0 && !low_power_hold_in)
    begin
      case (avs_address_in)
        `OFS_MODE:
          converter_mode_register_d = avs_writedata_in[7:0] | `MODE_RSVD;
        `OFS_IRQ_MASK:
          conversion_done_enable_d = avs_writedata_in[0];
        `OFS_PORT_MODE:
          trigger_pin_function_bit_d = avs_writedata_in[`BIT_PIN_FUNC];
        `OFS_EDGE_SEL:
          trigger_edge_select_d = avs_writedata_in[`BIT_EDGE_SEL];
        `OFS_CLK_STOP:
          converter_clock_stop_bit_d = avs_writedata_in[`BIT_CLK_STOP];
        default:
          converter_mode_register_d = converter_mode_register_q;
      endcase
    end
  end

  always_comb
  begin
    ack_d   = (avs_read_in || avs_write_in) && !ack_q;
    rdata_d = 32'h0000_0000;
    if (rd_hit)
    begin
      case (avs_address_in)
        `OFS_MODE:
          rdata_d[7:0] = converter_mode_register_q;
        `OFS_START:
          rdata_d[7:0] = {conversion_flag_q, `START_RSVD};
        `OFS_RES_HIGH:
          rdata_d[7:0] = result_q[RES_W-1:RES_W-8];
        `OFS_RES_LOW:
          rdata_d[7:6] = result_q[1:0];
        `OFS_IRQ_STATUS:
          rdata_d[0] = conversion_done_request_q;
        `OFS_IRQ_MASK:
          rdata_d[0] = conversion_done_enable_q;
        `OFS_PORT_MODE:
          rdata_d[`BIT_PIN_FUNC] = trigger_pin_function_bit_q;
        `OFS_EDGE_SEL:
          rdata_d[`BIT_EDGE_SEL] = trigger_edge_select_q;
        `OFS_CLK_STOP:
          rdata_d[`BIT_CLK_STOP] = converter_clock_stop_bit_q;
        default:
          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state_q                    <= ST_IDLE;
      conversion_flag_q          <= 1'b0;
      converter_mode_register_q  <= `MODE_RESET;
      conversion_done_request_q  <= 1'b0;
      conversion_done_enable_q   <= 1'b0;
      trigger_pin_function_bit_q <= 1'b0;
      trigger_edge_select_q      <= 1'b0;
      converter_clock_stop_bit_q <= 1'b1;
      cycle_q                    <= 7'h00;
      trig_prev_q                <= 1'b0;
      ack_q                      <= 1'b0;
      rdata_q                    <= 32'h0000_0000;
      irq_q                      <= 1'b0;
      chan_one_q                 <= 1'b0;
    end
    else
    begin
      state_q                    <= state_d;
      conversion_flag_q          <= conversion_flag_d;
      converter_mode_register_q  <= converter_mode_register_d;
      conversion_done_request_q  <= conversion_done_request_d;
      conversion_done_enable_q   <= conversion_done_enable_d;
      trigger_pin_function_bit_q <= trigger_pin_function_bit_d;
      trigger_edge_select_q      <= trigger_edge_select_d;
      converter_clock_stop_bit_q <= converter_clock_stop_bit_d;
      cycle_q                    <= cycle_d;
      trig_prev_q                <= external_trigger_pin_in;
      ack_q                      <= ack_d;
      rdata_q                    <= rdata_d;
      irq_q <= conversion_done_request_d && conversion_done_enable_d;
      chan_one_q <= converter_mode_register_d[3:0] == 4'h5;
    end
  end

  // Results are not reset so they survive a reset.
  always_ff @(posedge core_clk_in)
  begin
    result_q <= result_d;
  end

  // Trial code and channel come straight from flip-flops.
  logic [RES_W-1:0] trial_q;
  logic [3:0]       chan_q;
  logic             clk_on_q;
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      trial_q  <= '0;
      chan_q   <= 4'h0;
      clk_on_q <= 1'b1;
    end
    else
    begin
      trial_q  <= trial;
      chan_q   <= converter_mode_register_d[3:0];
      clk_on_q <= converter_clock_stop_bit_d;
    end
  end

  assign avs_readdata_out         = rdata_q;
  assign avs_waitrequest_out      = !ack_q;
  assign dac_trial_out            = trial_q;
  assign channel_select_field_out = chan_q;
  assign analog_input_one_sel_out = chan_one_q;
  assign converter_clock_on_out   = clk_on_q;
  assign irq_out                  = irq_q;
endmodule

/* src/adc_seq_defs.svh */
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a 100 MHz system clock and word-indexed Avalon-MM addresses, one offset per register.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define OFS_MODE        4'h0
`define OFS_START       4'h1
`define OFS_RES_HIGH    4'h2
`define OFS_RES_LOW     4'h3
`define OFS_IRQ_STATUS  4'h4
`define OFS_IRQ_MASK    4'h5
`define OFS_PORT_MODE   4'h6
`define OFS_EDGE_SEL    4'h7
`define OFS_CLK_STOP    4'h8
`define MODE_RESET      8'h30
`define MODE_RSVD       8'h30
`define START_RSVD      7'h7F
`define BIT_SPEED       7
`define BIT_TRG_EN      6
`define BIT_DONE_FLAG   7
`define BIT_PIN_FUNC    4
`define BIT_EDGE_SEL    4
`define BIT_CLK_STOP    4
`define CONV_CYC_SLOW   7'h3E
`define CONV_CYC_FAST   7'h1F
`define RES_BITS        10
`endif

/* src/adc_seq_pkg.sv */
// Types shared by the conversion sequencer files.
// Assumes nothing beyond the defines header.
package adc_seq_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;
  typedef logic [7:0] reg_byte_t;
endpackage

/* src/sar_engine.sv */
// Successive approximation engine: one result bit decided per step.
// Assumes the analog comparator answers within one clock.
module sar_engine #(
  parameter int BITS = 10
) (
  // Clock and reset.
  input  wire logic            core_clk_in,
  input  wire logic            reset_in,
  // Control.
  input  wire logic            clear_in,
  input  wire logic            step_in,
  // Comparator.
  input  wire logic            cmp_above_in,
  output logic [BITS-1:0]      trial_out
);
  logic [BITS-1:0] code_q;
  logic [BITS-1:0] code_d;
  logic [BITS-1:0] probe_q;
  logic [BITS-1:0] probe_d;

  always_comb
  begin
    code_d  = code_q;
    probe_d = probe_q;
    if (clear_in)
    begin
      code_d  = '0;
      probe_d = {1'b1, {(BITS-1){1'b0}}};
    end
    else if (step_in && probe_q != '0)
    begin
      if (cmp_above_in)
        code_d = code_q | probe_q;
      probe_d = probe_q >> 1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      code_q  <= '0;
      probe_q <= '0;
    end
    else
    begin
      code_q  <= code_d;
      probe_q <= probe_d;
    end
  end

  assign trial_out = code_q | probe_q;
endmodule

/* verification/adc_seq_monitor.sv */
// Checker of the sequencer's register port, channel pins and interrupt.
// Assumes it is bound to the sequencer and sees only its ports.
`include "adc_seq_defs.svh"
module adc_seq_monitor (
  // Clock and reset.
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // Register bus.
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_readdata_out,
  input  wire logic        avs_waitrequest_out,
  // Side pins.
  input  wire logic        low_power_hold_in,
  input  wire logic [3:0]  channel_select_field_out,
  input  wire logic        analog_input_one_sel_out,
  input  wire logic        converter_clock_on_out,
  input  wire logic        irq_out
);
  logic wr_ok;
  logic clr;
  logic mask_q;
  logic mask_d;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  assign wr_ok = avs_write_in && avs_waitrequest_out
    && avs_byteenable_in[0] && !low_power_hold_in;
  assign clr = wr_ok && (avs_address_in == `OFS_IRQ_STATUS
    || avs_address_in == `OFS_IRQ_MASK);
  always_comb
  begin
    mask_d = mask_q;
    if (wr_ok && avs_address_in == `OFS_IRQ_MASK)
      mask_d = avs_writedata_in[0];
  end
  always_ff @(posedge core_clk_in)
    if (reset_in)
      mask_q <= 1'b0;
    else
      mask_q <= mask_d;
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ack_once;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_one_wait: assert property (s_req |=> s_ack_once)
    else $error("waitrequest not low for exactly one cycle");
  a_no_idle_ack: assert property
    (!(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("ack without a request");
  a_start_pad: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in == `OFS_START |-> avs_readdata_out[6:0] == 7'h7F)
    else $error("start register pad bits wrong");
  a_chan_write: assert property (wr_ok
    && avs_address_in == `OFS_MODE
    |=> channel_select_field_out == $past(avs_writedata_in[3:0]))
    else $error("channel field not written");
  a_sel_one: assert property
    (analog_input_one_sel_out == (channel_select_field_out == 4'h5))
    else $error("input one select wrong");
  a_hold_keeps: assert property (low_power_hold_in && avs_write_in
    |=> $stable(channel_select_field_out))
    else $error("write took effect during hold");
  a_clk_write: assert property (wr_ok
    && avs_address_in == `OFS_CLK_STOP |=> converter_clock_on_out
    == $past(avs_writedata_in[`BIT_CLK_STOP]))
    else $error("clock stop bit not written");
  a_irq_masked: assert property (irq_out |-> mask_q || $past(mask_q))
    else $error("interrupt while masked");
  a_irq_sticky: assert property (irq_out && !clr && !$past(clr)
    |=> irq_out)
    else $error("interrupt dropped without clear");
endmodule
bind adc_conversion_sequencer adc_seq_monitor i_adc_seq_monitor (
  .core_clk_in, .reset_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
  .avs_readdata_out, .avs_waitrequest_out, .low_power_hold_in,
  .channel_select_field_out, .analog_input_one_sel_out,
  .converter_clock_on_out, .irq_out
);

/* verification/adc_conversion_sequencer_bench.sv */
// Bench for the sequencer: register, timing, trigger and interrupt tests.
// Assumes the design files and the monitor are compiled before it.
`include "adc_seq_defs.svh"
module adc_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wreq;
  logic        trg;
  logic        hold;
  logic [9:0]  ain;
  logic [9:0]  trial;
  logic [3:0]  chan;
  logic        sel1;
  logic        clkon;
  logic        irq;
  logic [31:0] q;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t_slow;
  int          t_fast;
  int          t_re;
  adc_conversion_sequencer i_adc_conversion_sequencer (
    .core_clk_in(clk), .reset_in(rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .external_trigger_pin_in(trg),
    .low_power_hold_in(hold), .cmp_above_in(ain >= trial),
    .dac_trial_out(trial), .channel_select_field_out(chan),
    .analog_input_one_sel_out(sel1), .converter_clock_on_out(clkon),
    .irq_out(irq)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdk(string nm, logic [3:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic conv(int k, output int n);
    int t0;
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    bus(1'b1, `OFS_START, 32'h80);
    t0 = cyc;
    rdk("busy", `OFS_START, 32'hFF);
    if (k > 0)
    begin
      repeat (k) @(posedge clk);
      bus(1'b1, `OFS_START, 32'h80);
    end
    while (irq !== 1'b1 && cyc - t0 < 200)
      @(posedge clk);
    n = cyc - t0;
    rdk("done", `OFS_START, 32'h7F);
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("status", q[0], 1'b1);
    rdk("res_hi", `OFS_RES_HIGH, {24'h0, ain[9:2]});
    bus(1'b0, `OFS_RES_LOW, 32'h0);
    chk("res_lo", q[7:6], ain[1:0]);
  endtask
  task automatic pin(logic v, logic b);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    trg <= v;
    repeat (3) @(posedge clk);
    bus(1'b0, `OFS_START, 32'h0);
    chk("trig_busy", q[7], b);
    repeat (70) @(posedge clk);
    chk("trig_irq", irq, b);
  endtask
  initial
  begin
    rst = 1'b1;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    trg = 1'b0;
    hold = 1'b0;
    ain = 10'h2B7;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdk("mode", `OFS_MODE, 32'h30);
    rdk("start", `OFS_START, 32'h7F);
    rdk("unmapped", 4'hC, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `OFS_MODE, 32'h05);
    chk("an1_sel", sel1, 1'b1);
    conv(0, t_slow);
    bus(1'b1, `OFS_MODE, 32'h85);
    ain <= 10'h15A;
    conv(0, t_fast);
    chk("period", t_slow - t_fast, 31);
    conv(8, t_re);
    chk("no_restart", t_re, t_fast);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    bus(1'b1, `OFS_START, 32'h80);
    bus(1'b1, `OFS_START, 32'h0);
    repeat (70) @(posedge clk);
    rdk("stopped", `OFS_START, 32'h7F);
    chk("irq_off", irq, 1'b0);
    rdk("res_keep", `OFS_RES_HIGH, {24'h0, ain[9:2]});
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    conv(0, t_re);
    chk("masked", irq, 1'b0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    @(posedge clk);
    chk("unmasked", irq, 1'b1);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    @(posedge clk);
    chk("cleared", irq, 1'b0);
    hold <= 1'b1;
    bus(1'b1, `OFS_MODE, 32'h0A);
    chk("hold_chan", chan, 4'h5);
    hold <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdk("rst_res", `OFS_RES_HIGH, {24'h0, ain[9:2]});
    bus(1'b1, `OFS_CLK_STOP, 32'h0);
    chk("clk_off", clkon, 1'b0);
    bus(1'b1, `OFS_START, 32'h80);
    rdk("standby", `OFS_START, 32'h7F);
    bus(1'b1, `OFS_CLK_STOP, 32'h10);
    repeat (10) @(posedge clk);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `OFS_EDGE_SEL, 32'h10);
    bus(1'b1, `OFS_PORT_MODE, 32'h10);
    bus(1'b1, `OFS_MODE, 32'h05);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    bus(1'b1, `OFS_MODE, 32'h45);
    bus(1'b1, `OFS_PORT_MODE, 32'h0);
    pin(1'b1, 1'b0);
    bus(1'b1, `OFS_PORT_MODE, 32'h10);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b1);
    bus(1'b1, `OFS_EDGE_SEL, 32'h0);
    pin(1'b0, 1'b1);
    summarize();
  end
endmodule
